// ===== hw/rgs_clock_ctrl.sv
// Real-time clock control: counters, selective clears, precise start,
// rollover flag, isolation input, fast-count mode and compare latch.
// Assumes host bus pins and the oscillator are asynchronous to mclk.
`timescale 1ns/1ps
//
// Contract
// - Write code 10010 clears counters selectively, 10011 clears latches selectively.
// - Data bit D0 selects thousandths, upward one group per bit, D7 months.
// - Isolation input low makes the device ignore all bus pins and float the data outputs; the oscillator keeps counting.
// - Writing FF at 12H clears all counters, at 13H all compare RAM.
// - Write at 15H clears sub-minute counters, whatever the data.
// - Precise start with seconds above 39 increments minutes, else minutes stay.
// - A 1 kHz tick during or after a counter read sets the rollover flag.
// - Read at 14H returns the rollover flag on D0, zeros elsewhere.
// - Trailing edge of a read at 14H clears the rollover flag.
// - Fast-count mode feeds raw oscillator edges into the fastest counter.
// - A 32,768 Hz time base is divided down to the counter clock.
// - Compare RAM shares the counter layout; unused bits match only zeros.
// - Codes 01000 to 01111 address compare latches, thousandths to months.
// - Compare result latches 61 us after each counter tick outside fast-count mode.
module rgs_clock_ctrl (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic oscIn,
	input wire logic isolate_n,
	input wire logic csN,
	input wire logic rdN,
	input wire logic wrN,
	input wire logic [rgs_pkg::ADDR_W-1:0] addr,
	input wire logic [rgs_pkg::DATA_W-1:0] dataIn,
	output logic [rgs_pkg::DATA_W-1:0] dataOut,
	output logic dataOeN,
	output logic compareMatch,
	output logic fastCountActive
);
	import rgs_pkg::*;

	typedef enum {SCAN_IDLE, SCAN_WAIT, SCAN_RUN} rgs_scan_t;

	logic [PIN_W-1:0] pinS;
	logic isoOk;
	logic rdActive;
	logic wrActive;
	logic rdPrev;
	logic wrPrev;
	logic rdStart;
	logic rdEnd;
	logic wrEnd;
	logic [ADDR_W-1:0] addrS;
	logic [DATA_W-1:0] dataS;
	logic [ADDR_W-1:0] wrAddr;
	logic [DATA_W-1:0] wrData;
	logic [ADDR_W-1:0] rdAddr;
	logic oscPrev;
	logic oscRise;
	logic [ACC_W-1:0] acc;
	logic [ACC_W-1:0] accSum;
	logic tick;
	logic [7:0] cnt [NUM_GROUPS];
	logic [7:0] incVal [NUM_GROUPS];
	logic [NUM_GROUPS:0] carry;
	logic [NUM_GROUPS-1:0] cntClr;
	logic [NUM_GROUPS-1:0] ramClr;
	logic cntLoad;
	logic ramLoad;
	logic goCmd;
	logic goBump;
	logic rollFlag;
	logic readArmed;
	logic cntReading;
	logic flagRdEnd;
	logic [DATA_W-1:0] ramHostData;
	logic [DATA_W-1:0] ramScanData;
	rgs_scan_t scanState;
	logic [9:0] delayCnt;
	logic [2:0] scanIdx;
	logic [2:0] cmpIdx;
	logic scanValid;
	logic matchAcc;
	logic [DATA_W-1:0] next_dataOut;

	function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic hiOnly);
		logic [7:0] r;
		r = v;
		if (hiOnly || v[3:0] == 4'h9) begin
			r = {v[7:4] + 4'h1, 4'h0};
		end else begin
			r = {v[7:4], v[3:0] + 4'h1};
		end
		return r;
	endfunction

	rgs_pin_sync #(
		.W(PIN_W),
		.RESET_VAL(PIN_RESET)
	) u_sync (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.pinIn({oscIn, isolate_n, csN, rdN, wrN, addr, dataIn}),
		.syncOut(pinS)
	);

	assign addrS = pinS[PIN_ADDR_LO +: ADDR_W];
	assign dataS = pinS[DATA_W-1:0];
	// Isolation acts as a second chip select on every strobe
	assign isoOk = pinS[PIN_ISO];
	assign rdActive = isoOk & ~pinS[PIN_CS] & ~pinS[PIN_RD];
	assign wrActive = isoOk & ~pinS[PIN_CS] & ~pinS[PIN_WR];
	assign fastCountActive = wrActive && addrS == ADDR_FAST;

	// Trailing edges only count while not isolated, so dropping isolation
	// mid-access never fires a stale write
	assign rdStart = rdActive & ~rdPrev;
	assign rdEnd = rdPrev & ~rdActive & isoOk;
	assign wrEnd = wrPrev & ~wrActive & isoOk;

	always_ff @(posedge mclk) begin
		if (rst) begin
			rdPrev <= 1'b0;
			wrPrev <= 1'b0;
			wrAddr <= '0;
			wrData <= '0;
			rdAddr <= '0;
		end else if (ce) begin
			rdPrev <= rdActive;
			wrPrev <= wrActive;
			if (wrActive) begin
				wrAddr <= addrS;
				wrData <= dataS;
			end
			if (rdActive) begin
				rdAddr <= addrS;
			end
		end
	end

	// Write decode, one action per trailing edge
	always_comb begin
		cntLoad = wrEnd && wrAddr[4:3] == ADDR_CNT_BASE[4:3];
		ramLoad = wrEnd && wrAddr[4:3] == ADDR_RAM_BASE[4:3];
		cntClr = (wrEnd && wrAddr == ADDR_CNT_CLEAR) ? wrData : '0;
		ramClr = (wrEnd && wrAddr == ADDR_RAM_CLEAR) ? wrData : '0;
		goCmd = wrEnd && wrAddr == ADDR_GO;
	end

	// Fractional divider: 1000 per oscillator edge, tick on wrap of 32768
	assign accSum = acc + ACC_STEP;
	assign oscRise = pinS[PIN_OSC] & ~oscPrev;

	always_ff @(posedge mclk) begin
		if (rst) begin
			oscPrev <= 1'b0;
			acc <= '0;
		end else if (ce) begin
			oscPrev <= pinS[PIN_OSC];
			if (oscRise) begin
				acc <= (accSum >= ACC_WRAP) ? accSum - ACC_WRAP : accSum;
			end
		end
	end

	// Fast-count mode bypasses the divider entirely
	assign tick = oscRise & (fastCountActive | (accSum >= ACC_WRAP));

	// Precise start carries into minutes when seconds already past 39
	assign goBump = goCmd && cnt[GRP_SEC] > GO_SEC_LIMIT;
	assign carry[0] = tick;

	generate
		for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
			logic atTop;
			assign atTop = cnt[g] == GRP_TOP[g];
			assign incVal[g] = atTop ? GRP_BOTTOM[g] : bcd_step(cnt[g], g == GRP_MS);
			if (g == GRP_MIN - 1) begin : g_go
				assign carry[g+1] = (carry[g] & atTop) | goBump;
			end else begin : g_plain
				assign carry[g+1] = carry[g] & atTop;
			end

			always_ff @(posedge mclk) begin
				if (rst) begin
					cnt[g] <= GRP_BOTTOM[g];
				end else if (ce) begin
					if (cntClr[g] || (goCmd && g <= GRP_SEC)) begin
						cnt[g] <= GRP_BOTTOM[g];
					end else if (cntLoad && wrAddr[2:0] == 3'(g)) begin
						cnt[g] <= wrData & GRP_USED[g];
					end else if (carry[g]) begin
						cnt[g] <= incVal[g];
					end
				end
			end
		end
	endgenerate

	rgs_cmp_ram #(
		.DEPTH(NUM_GROUPS),
		.AW(3),
		.W(DATA_W)
	) u_ram (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.wrEn(ramLoad),
		.wrAddr(wrAddr[2:0]),
		.wrData(wrData),
		.clrMask(ramClr),
		.hostAddr(addrS[2:0]),
		.hostData(ramHostData),
		.scanAddr(scanIdx),
		.scanData(ramScanData)
	);

	// Rollover flag: armed by a counter read, set by the next tick
	assign cntReading = rdActive && addrS[4:3] == ADDR_CNT_BASE[4:3];
	assign flagRdEnd = rdEnd && rdAddr == ADDR_ROLL_FLAG;

	always_ff @(posedge mclk) begin
		if (rst) begin
			readArmed <= 1'b0;
		end else if (ce) begin
			if (rdStart && cntReading) begin
				readArmed <= 1'b1;
			end else if (flagRdEnd) begin
				readArmed <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rollFlag <= 1'b0;
		end else if (ce) begin
			// A tick in the clearing cycle still sets the flag
			if (tick && (cntReading || readArmed)) begin
				rollFlag <= 1'b1;
			end else if (flagRdEnd) begin
				rollFlag <= 1'b0;
			end
		end
	end

	// Read data mux, registered onto the pins
	always_comb begin
		next_dataOut = '0;
		if (addrS[4:3] == ADDR_CNT_BASE[4:3]) begin
			next_dataOut = cnt[addrS[2:0]];
		end else if (addrS[4:3] == ADDR_RAM_BASE[4:3]) begin
			next_dataOut = ramHostData;
		end else if (addrS == ADDR_ROLL_FLAG) begin
			next_dataOut[ROLL_BIT] = rollFlag;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			dataOut <= '0;
			dataOeN <= 1'b1;
		end else if (ce) begin
			dataOut <= rdActive ? next_dataOut : '0;
			dataOeN <= ~rdActive;
		end
	end

	// Compare scan: wait out counter ripple, then walk the eight groups.
	// A tick arriving mid-wait does not restart it, so fast-count mode
	// still latches roughly every third tick.
	always_ff @(posedge mclk) begin
		if (rst) begin
			scanState <= SCAN_IDLE;
			delayCnt <= '0;
			scanIdx <= '0;
			cmpIdx <= '0;
			scanValid <= 1'b0;
			matchAcc <= 1'b0;
			compareMatch <= 1'b0;
		end else if (ce) begin
			scanValid <= 1'b0;
			cmpIdx <= scanIdx;
			case (scanState)
				SCAN_IDLE: begin
					if (tick) begin
						delayCnt <= 10'(LATCH_DELAY_CYC - 1);
						scanState <= SCAN_WAIT;
					end
				end
				SCAN_WAIT: begin
					if (delayCnt == '0) begin
						scanIdx <= '0;
						matchAcc <= 1'b1;
						scanState <= SCAN_RUN;
					end else begin
						delayCnt <= delayCnt - 10'h001;
					end
				end
				SCAN_RUN: begin
					scanIdx <= scanIdx + 3'h1;
					scanValid <= 1'b1;
					if (scanIdx == 3'h7) begin
						scanState <= SCAN_IDLE;
					end
				end
				default: begin
					scanState <= SCAN_IDLE;
				end
			endcase
			if (scanValid) begin
				// Unused counter bits read zero, so RAM must hold zero there
				if (cmpIdx == 3'h7) begin
					compareMatch <= matchAcc && (ramScanData == cnt[cmpIdx]);
				end else begin
					matchAcc <= matchAcc && (ramScanData == cnt[cmpIdx]);
				end
			end
		end
	end
endmodule // rgs_clock_ctrl

// ===== hw/rgs_cmp_ram.sv
// Compare RAM: one byte per digit group, two registered read ports.
// Assumes one writer; a clear of an entry wins over a write to it.
`timescale 1ns/1ps
module rgs_cmp_ram #(
	parameter int DEPTH = 8,
	parameter int AW = 3,
	parameter int W = 8
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [W-1:0] wrData,
	input wire logic [DEPTH-1:0] clrMask,
	input wire logic [AW-1:0] hostAddr,
	output logic [W-1:0] hostData,
	input wire logic [AW-1:0] scanAddr,
	output logic [W-1:0] scanData
);
	logic [W-1:0] mem [DEPTH];

	generate
		if (DEPTH != (1 << AW)) begin : g_chk
			$error("rgs_cmp_ram: DEPTH must equal 2**AW");
		end
		for (genvar e = 0; e < DEPTH; e++) begin : g_entry
			always_ff @(posedge mclk) begin
				if (rst) begin
					mem[e] <= '0;
				end else if (ce) begin
					if (clrMask[e]) begin
						mem[e] <= '0;
					end else if (wrEn && wrAddr == AW'(e)) begin
						mem[e] <= wrData;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (rst) begin
			hostData <= '0;
			scanData <= '0;
		end else if (ce) begin
			hostData <= mem[hostAddr];
			scanData <= mem[scanAddr];
		end
	end
endmodule // rgs_cmp_ram

// ===== hw/rgs_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs are asynchronous to mclk; output moves only when the
// second and third stages agree.
`timescale 1ns/1ps
module rgs_pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] syncOut
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;
	logic [W-1:0] agree;

	generate
		if (W < 1) begin : g_chk
			$error("rgs_pin_sync: W must be at least 1");
		end
	endgenerate

	assign agree = ~(stage2 ^ stage3);

	always_ff @(posedge mclk) begin
		if (rst) begin
			stage1 <= RESET_VAL;
			stage2 <= RESET_VAL;
			stage3 <= RESET_VAL;
			syncOut <= RESET_VAL;
		end else if (ce) begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
			syncOut <= (stage3 & agree) | (syncOut & ~agree);
		end
	end
endmodule // rgs_pin_sync

// ===== pkg/rgs_pkg.sv
// Shared constants for the clock control block: address codes, counter
// digit layout, time base and comparator latch timing.
// Assumes a 10 MHz system clock and a 32,768 Hz oscillator on a pin.
package rgs_pkg;

	localparam int CLK_HZ = 10_000_000;
	localparam int OSC_HZ = 32_768;
	localparam int TICK_HZ = 1_000;
	localparam int LATCH_DELAY_US = 61;
	// Least delay rounds up to whole clock cycles
	localparam int LATCH_DELAY_CYC = (LATCH_DELAY_US * (CLK_HZ / 1_000) + 999) / 1_000;

	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int NUM_GROUPS = 8;
	localparam int ACC_W = 16;

	localparam logic [ACC_W-1:0] ACC_STEP = 16'h03e8;
	localparam logic [ACC_W-1:0] ACC_WRAP = 16'h8000;

	localparam logic [4:0] ADDR_CNT_BASE = 5'h00;
	localparam logic [4:0] ADDR_RAM_BASE = 5'h08;
	localparam logic [4:0] ADDR_CNT_CLEAR = 5'h12;
	localparam logic [4:0] ADDR_RAM_CLEAR = 5'h13;
	localparam logic [4:0] ADDR_ROLL_FLAG = 5'h14;
	localparam logic [4:0] ADDR_GO = 5'h15;
	localparam logic [4:0] ADDR_FAST = 5'h1f;

	localparam int GRP_MS = 0;
	localparam int GRP_SEC = 2;
	localparam int GRP_MIN = 3;
	localparam int ROLL_BIT = 0;
	localparam logic [7:0] GO_SEC_LIMIT = 8'h39;

	// Per group: thousandths, hund/tenths, sec, min, hour, dow, dom, month
	localparam logic [7:0] GRP_USED [NUM_GROUPS] = '{8'hf0, 8'hff, 8'h7f, 8'h7f,
		8'h3f, 8'h07, 8'h3f, 8'h1f};
	localparam logic [7:0] GRP_TOP [NUM_GROUPS] = '{8'h90, 8'h99, 8'h59, 8'h59,
		8'h23, 8'h07, 8'h31, 8'h12};
	localparam logic [7:0] GRP_BOTTOM [NUM_GROUPS] = '{8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h01, 8'h01, 8'h01};

	// Pin bundle layout after synchronisation
	localparam int PIN_W = 18;
	localparam int PIN_OSC = 17;
	localparam int PIN_ISO = 16;
	localparam int PIN_CS = 15;
	localparam int PIN_RD = 14;
	localparam int PIN_WR = 13;
	localparam int PIN_ADDR_LO = 8;
	localparam logic [PIN_W-1:0] PIN_RESET = 18'h1e000;

endpackage

// ===== tb/rgs_clock_ctrl_monitor.sv
// Port checker for the clock control block.
// Assumes one mclk domain and ce held high.
`timescale 1ns/1ps
module rgs_clock_ctrl_monitor (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic oscIn,
	input wire logic isolate_n,
	input wire logic csN,
	input wire logic rdN,
	input wire logic wrN,
	input wire logic [rgs_pkg::ADDR_W-1:0] addr,
	input wire logic [rgs_pkg::DATA_W-1:0] dataIn,
	input wire logic [rgs_pkg::DATA_W-1:0] dataOut,
	input wire logic dataOeN,
	input wire logic compareMatch,
	input wire logic fastCountActive
);
	import rgs_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic [9:0] sinceRst;
	always_ff @(posedge mclk) begin
		if (rst) begin
			sinceRst <= 10'h000;
		end else if (sinceRst != 10'h3ff) begin
			sinceRst <= sinceRst + 10'h001;
		end
	end
	sequence rdHeld;
		(isolate_n && !csN && !rdN)[*6];
	endsequence
	sequence flagRdHeld;
		(isolate_n && !csN && !rdN && addr == ADDR_ROLL_FLAG)[*6];
	endsequence
	sequence fastHeld;
		(isolate_n && !csN && !wrN && addr == ADDR_FAST)[*5];
	endsequence
	a_read_drives_bus: assert property (rdHeld |-> !dataOeN)
		else $error("bus not driven during read");
	a_flag_read_shape: assert property (flagRdHeld |-> dataOut[7:1] == 7'h00)
		else $error("flag read upper bits not zero");
	a_isolated_quiet: assert property ((!isolate_n)[*6] |-> dataOeN)
		else $error("bus driven while isolated");
	a_idle_zero_data: assert property (dataOeN |-> dataOut == 8'h00)
		else $error("data not zero when idle");
	a_drive_needs_read: assert property (!dataOeN |-> $past(rdN, 5) == 1'b0)
		else $error("bus driven without read strobe");
	a_fast_cause: assert property (fastCountActive |-> $past(wrN, 4) == 1'b0)
		else $error("fast count without write strobe");
	a_fast_entry: assert property (fastHeld |-> fastCountActive)
		else $error("fast count not entered");
	a_boot_no_match: assert property (sinceRst < 10'd615 |-> !compareMatch)
		else $error("compare latched too early");
endmodule // rgs_clock_ctrl_monitor

bind rgs_clock_ctrl rgs_clock_ctrl_monitor rgs_clock_ctrl_monitor_inst (.mclk(mclk),
	.rst(rst), .ce(ce), .oscIn(oscIn), .isolate_n(isolate_n), .csN(csN), .rdN(rdN),
	.wrN(wrN), .addr(addr), .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN),
	.compareMatch(compareMatch), .fastCountActive(fastCountActive));

// ===== tb/rgs_clock_ctrl_tb.sv
// Self-checking bench for the clock control block.
// Assumes the host model and the bound port checker.
`timescale 1ns/1ps
module rgs_clock_ctrl_tb;
	import rgs_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic oscIn = 1'b0;
	logic isolate_n = 1'b1;
	logic csN, rdN, wrN, dataOeN, compareMatch, fastCountActive;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] dataIn, dataOut;
	int error_cnt = 0;
	int check_count = 0;
	always #50 mclk = ~mclk;
	always #15259 oscIn = ~oscIn;
	rgs_clock_ctrl rgs_clock_ctrl_inst (.mclk(mclk), .rst(rst), .ce(ce), .oscIn(oscIn),
		.isolate_n(isolate_n), .csN(csN), .rdN(rdN), .wrN(wrN), .addr(addr),
		.dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN),
		.compareMatch(compareMatch), .fastCountActive(fastCountActive));
	rgs_host_model rgs_host_model_inst (.mclk(mclk), .dataOut(dataOut), .dataOeN(dataOeN),
		.csN(csN), .rdN(rdN), .wrN(wrN), .addr(addr), .dataIn(dataIn));
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk1(input string n, input logic e, input logic g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic w(input logic [4:0] a, input logic [7:0] d);
		rgs_host_model_inst.wr_reg(a, d);
	endtask
	// A read the device does not answer shows as unknown
	task automatic rdv(input string n, input logic [4:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic ok;
		rgs_host_model_inst.rd_reg(a, d, ok);
		if (ok !== 1'b1)
			d = 8'hxx;
		chk8(n, e, d);
	endtask
	task automatic t_reset();
		chk1("idle oe", 1'b1, dataOeN);
		rdv("month", 5'h07, 8'h01);
		rdv("latch min", 5'h0b, 8'h00);
	endtask
	task automatic t_go();
		w(5'h02, 8'h45);
		w(5'h03, 8'h07);
		w(ADDR_GO, 8'ha5);
		rdv("sec go", 5'h02, 8'h00);
		rdv("min go", 5'h03, 8'h08);
		w(5'h02, 8'h39);
		w(ADDR_GO, 8'h00);
		rdv("min 39", 5'h03, 8'h08);
	endtask
	task automatic t_selclr();
		w(5'h02, 8'h21);
		w(5'h07, 8'h12);
		w(ADDR_CNT_CLEAR, 8'h08);
		rdv("min clr", 5'h03, 8'h00);
		rdv("sec kept", 5'h02, 8'h21);
		w(ADDR_CNT_CLEAR, 8'hff);
		rdv("sec all", 5'h02, 8'h00);
		rdv("month all", 5'h07, 8'h01);
	endtask
	// Thousandths latch left alone here, as host code should
	task automatic t_latch();
		w(5'h0b, 8'h5a);
		w(5'h0a, 8'h33);
		rdv("latch wr", 5'h0b, 8'h5a);
		w(ADDR_RAM_CLEAR, 8'h08);
		rdv("latch clr", 5'h0b, 8'h00);
		rdv("latch kept", 5'h0a, 8'h33);
		w(ADDR_RAM_CLEAR, 8'hff);
		rdv("latch all", 5'h0a, 8'h00);
	endtask
	// Model has no ripple, so thousandths may take part; first tick is far off
	task automatic t_match();
		int n;
		w(5'h0d, 8'h01);
		w(5'h0e, 8'h01);
		w(5'h0f, 8'h01);
		w(5'h08, 8'h10);
		w(ADDR_CNT_CLEAR, 8'hff);
		chk1("match idle", 1'b0, compareMatch);
		n = 0;
		while (compareMatch !== 1'b1 && n < 12000) begin
			@(negedge mclk);
			n++;
		end
		chk1("match tick", 1'b1, compareMatch);
		rdv("ms tick", 5'h00, 8'h10);
	endtask
	task automatic t_flag();
		logic [7:0] d;
		logic ok;
		rgs_host_model_inst.rd_reg(ADDR_ROLL_FLAG, d, ok);
		rdv("flag clr", ADDR_ROLL_FLAG, 8'h00);
		rgs_host_model_inst.rd_reg(5'h00, d, ok);
		repeat (15000) @(negedge mclk);
		rdv("flag set", ADDR_ROLL_FLAG, 8'h01);
		rdv("flag gone", ADDR_ROLL_FLAG, 8'h00);
	endtask
	// Programming finishes before isolation is applied
	task automatic t_iso();
		logic [7:0] d;
		logic ok;
		w(5'h02, 8'h11);
		isolate_n = 1'b0;
		repeat (8) @(negedge mclk);
		w(5'h02, 8'h22);
		rgs_host_model_inst.rd_reg(5'h02, d, ok);
		chk1("iso drive", 1'b0, ok);
		isolate_n = 1'b1;
		repeat (8) @(negedge mclk);
		rdv("iso sec", 5'h02, 8'h11);
	endtask
	// About 42 oscillator edges against one or two normal ticks
	task automatic t_fast();
		logic [7:0] d;
		logic ok;
		w(ADDR_CNT_CLEAR, 8'hff);
		rgs_host_model_inst.hold_fast(13000);
		rgs_host_model_inst.rd_reg(5'h01, d, ok);
		chk1("fast count", 1'b1, ok && d >= 8'h03);
	endtask
	initial begin
		repeat (16) @(negedge mclk);
		rst = 1'b0;
		t_reset();
		t_go();
		t_selclr();
		t_latch();
		t_match();
		t_flag();
		t_iso();
		t_fast();
		tally_and_finish();
	end
	initial begin
		repeat (60000) @(posedge mclk);
		error_cnt++;
		tally_and_finish();
	end
endmodule // rgs_clock_ctrl_tb

// ===== tb/rgs_host_model.sv
// Host CPU model driving the clock block's I/O bus pins.
// Assumes strobes change at mclk falling edges only.
`timescale 1ns/1ps
module rgs_host_model (
	input wire logic mclk,
	input wire logic [rgs_pkg::DATA_W-1:0] dataOut,
	input wire logic dataOeN,
	output logic csN,
	output logic rdN,
	output logic wrN,
	output logic [rgs_pkg::ADDR_W-1:0] addr,
	output logic [rgs_pkg::DATA_W-1:0] dataIn
);
	import rgs_pkg::*;
	initial begin
		csN = 1'b1;
		rdN = 1'b1;
		wrN = 1'b1;
		addr = 5'h00;
		dataIn = 8'h00;
	end
	// Address and data held a cycle past the strobe, then scrambled
	task automatic release_bus();
		csN = 1'b1;
		rdN = 1'b1;
		wrN = 1'b1;
		@(negedge mclk);
		addr = ~addr;
		dataIn = ~dataIn;
		repeat (6) @(negedge mclk);
	endtask
	task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
		@(negedge mclk);
		addr = a;
		dataIn = d;
		csN = 1'b0;
		wrN = 1'b0;
		repeat (6) @(negedge mclk);
		release_bus();
	endtask
	task automatic rd_reg(input logic [4:0] a, output logic [7:0] d, output logic ok);
		@(negedge mclk);
		addr = a;
		csN = 1'b0;
		rdN = 1'b0;
		// Sampled off the launching edge, well after the registered answer
		repeat (7) @(negedge mclk);
		d = dataOut;
		ok = (dataOeN === 1'b0);
		@(negedge mclk);
		release_bus();
	endtask
	// Fast count lasts only while the strobe is held
	task automatic hold_fast(input int n);
		@(negedge mclk);
		addr = ADDR_FAST;
		csN = 1'b0;
		wrN = 1'b0;
		repeat (n) @(negedge mclk);
		release_bus();
	endtask
endmodule // rgs_host_model
